// ===== dv/mcsr_core_model.sv
/* mcsr_core_model: converter stand-in that answers the run bit.
   assumes conversion_run is a level from the bank on aclk. */
`timescale 1ns/1ps
module mcsr_core_model #(parameter int DLY = 20) (
   input  wire logic       aclk,
   input  wire logic       conversion_run,
   output logic            conversion_complete,
   output logic [7:0]      conversion_value
);
   int cnt = 0;
   initial conversion_complete = 1'b0;
   initial conversion_value = 8'h00;
   always @(posedge aclk) begin
      conversion_complete <= 1'b0;
      // value only means something beside the strobe, so it wanders otherwise
      conversion_value <= ~conversion_value;
      cnt <= conversion_run ? cnt + 1 : 0;
      if (conversion_run && cnt == DLY) begin
         conversion_complete <= 1'b1;
         conversion_value <= 8'hA5;
      end
   end
endmodule // mcsr_core_model

// ===== dv/test_mcsr_control_status_registers.sv
/* test_mcsr_control_status_registers: directed bench of mcsr_bank over AXI4-Lite.
   assumes mcsr_core_model finishes a conversion some cycles after run rises. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; $display("BAD %s %h %h", n, e, g); end end
module test_mcsr_control_status_registers;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awready;
   logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ext_irq_pin, timer_pin, comparator_out, irq_taken;
   logic conversion_complete, pulse1_period, pulse2_period, watchdog_osc_tick, enable_irq_instruction, amp2_enable;
   logic return_irq_instruction, disable_irq_instruction, bank_select, segment_select, conversion_run, amp1_enable;
   logic converter_power, vref_external, comparator_enable, comparator_output_mode, global_irq_enable, watchdog_tick;
   logic interrupt_pending;
   logic [1:0] s_axi_bresp, s_axi_rresp, converter_clock_divide, rsp;
   logic [2:0] input_channel_select, amp1_gain, amp2_gain;
   logic [3:0] s_axi_wstrb;
   logic [5:0] indirect_index;
   logic [7:0] s_axi_awaddr, s_axi_araddr, port5_pin, port6_pin, conversion_value, port5_out, port5_oe, port6_out;
   logic [7:0] port6_oe, analog_pin_mask, pull_down_disable_n, open_drain_disable_n, rv;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   int n_fail = 0;
   int compares = 0;
   mcsr_bank dut (.*);
   mcsr_core_model core (.aclk(aclk), .conversion_run(conversion_run), .conversion_complete(conversion_complete),
      .conversion_value(conversion_value));
   task automatic wr(input logic [5:0] i, input logic [7:0] d);
      @(posedge aclk);
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= {24'h0, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do @(negedge aclk); while (!(s_axi_awready && s_axi_wready));
      @(posedge aclk);
      {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
      do @(negedge aclk); while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] i);
      @(posedge aclk);
      s_axi_araddr <= {i, 2'b00};
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(negedge aclk); while (!s_axi_arready);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (!s_axi_rvalid);
      {rsp, rv} = {s_axi_rresp, s_axi_rdata[7:0]};
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask
   // order: pulse1, pulse2, enable, disable
   task automatic hit(input logic [3:0] w);
      @(posedge aclk);
      {pulse1_period, pulse2_period, enable_irq_instruction, disable_irq_instruction} <= w;
      @(posedge aclk);
      {pulse1_period, pulse2_period, enable_irq_instruction, disable_irq_instruction} <= 4'h0;
      @(negedge aclk);
   endtask
   task automatic t_map;
      rd(mcsr_pkg::IDX_TIMER_CTRL);
      `CHK("tctl", mcsr_pkg::RST_TIMER_CTRL, rv)
      `CHK("oe", 8'h00, port5_oe)
      wr(mcsr_pkg::IDX_RAM_SEL, 8'hC5);
      rd(mcsr_pkg::IDX_RAM_SEL);
      `CHK("rsel", 15'h45C5, {bank_select, indirect_index, rv})
      wr(mcsr_pkg::IDX_CONV_CTRL, 8'h20);
      rd(6'h25);
      `CHK("seg", 3'h7, {segment_select, rsp})
      wr(mcsr_pkg::IDX_CONV_CTRL, 8'h00);
      wr(6'h25, 8'h0F);
      `CHK("dir", 8'hF0, port5_oe)
      $display("t_map done");
   endtask
   task automatic t_cfg;
      wr(6'h29, 8'hE9);
      `CHK("gain", 8'hE9, {amp2_enable, amp1_enable, amp2_gain, amp1_gain})
      wr(6'h2A, 8'hEF);
      `CHK("cmp", 4'hF, {comparator_enable, comparator_output_mode, converter_clock_divide})
      `CHK("apin", 9'h10F, {vref_external, analog_pin_mask})
      wr(6'h2B, 8'h5A);
      wr(6'h2C, 8'hA5);
      `CHK("pins", 16'h5AA5, {pull_down_disable_n, open_drain_disable_n})
      $display("t_cfg done");
   endtask
   task automatic t_conv;
      wr(6'h2F, 8'h7F);
      wr(mcsr_pkg::IDX_CONV_CTRL, 8'h13);
      wr(mcsr_pkg::IDX_CONV_CTRL, 8'h0D);
      `CHK("run", 5'h1B, {conversion_run, converter_power, input_channel_select})
      for (int k = 0; k < 60 && conversion_run; k++) @(negedge aclk);
      rd(mcsr_pkg::IDX_CONV_RES);
      `CHK("res", 8'hA5, rv)
      rd(mcsr_pkg::IDX_FLAGS);
      `CHK("done", 9'h008, {conversion_run, rv})
      wr(mcsr_pkg::IDX_CONV_CTRL, 8'h06);
      `CHK("chlock", 3'h3, input_channel_select)
      wr(mcsr_pkg::IDX_FLAGS, 8'hFF);
      hit(4'hC);
      wr(mcsr_pkg::IDX_FLAGS, 8'h00);
      wr(mcsr_pkg::IDX_CONV_CTRL, 8'h06);
      rd(mcsr_pkg::IDX_FLAGS);
      `CHK("clr", 11'h600, {input_channel_select, rv})
      hit(4'hC);
      wr(6'h2F, 8'h90);
      rd(mcsr_pkg::IDX_FLAGS);
      `CHK("mask", 8'h10, rv)
      hit(4'h2);
      `CHK("gie", 1'b1, global_irq_enable)
      rd(mcsr_pkg::IDX_FLAGS);
      `CHK("pend", 1'b1, interrupt_pending)
      hit(4'h1);
      `CHK("gie0", 1'b0, global_irq_enable)
      $display("t_conv done");
   endtask
   task automatic wrap_up;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, ext_irq_pin, timer_pin} = '0;
      {comparator_out, pulse1_period, pulse2_period, watchdog_osc_tick, enable_irq_instruction, irq_taken} = '0;
      {return_irq_instruction, disable_irq_instruction, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {port5_pin, port6_pin, s_axi_wstrb} = 20'h0000F;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      t_map;
      t_cfg;
      t_conv;
      wrap_up;
   end
   initial begin
      repeat (5000) @(posedge aclk);
      n_fail++;
      wrap_up;
   end
endmodule // test_mcsr_control_status_registers

// ===== logic/mcsr_bank.sv
/*
 * mcsr_bank: special-function register bank with AXI4-Lite slave, interrupt
 * flags, timer/counter with shared prescaler and pin synchronisers.
 * Assumes pins and comparator output are asynchronous; converter, pulse and core
 * instruction strobes are single-cycle pulses on aclk.
 */
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
// Summary of operation
// R1: ram select bit 6 picks data bank, bits 5..0 the indirect register
// R2: converter control bit 5 switches control window to segment one
// R3: run bit starts conversion, hardware clears it, software cannot
// R4: channel code 0..7 picks input; writable only when done flag and run low
// R5: conversion end loads result, clears run, sets done flag
// R6: comparator change sets bit 6; pulse period ends set bits 5 and 4
// R7: done sets bit 3, external edge bit 2, port change bit 1, overflow bit 0
// R8: software may clear status flags, never set; bit 7 reads zero
// R9: status read returns flags anded with interrupt mask
// R10: a mask bit of one enables that interrupt source
// R11: timer control bit 7 picks external edge, zero rising, one falling
// R12: enable and return set global enable; disable or taken irq clear it
// R13: timer source bit zero counts clocks, one counts timer pin transitions
// R14: timer edge bit zero counts rising, one counts falling pin edges
// R15: prescaler serves timer when assign bit zero, watchdog when one
// R16: prescale code doubles ratio, timer 1:2..1:256, watchdog 1:1..1:128
// R17: direction bit one floats the pin, zero drives it
// R18: two amplifier enables off by default, two gain codes 1..32
// R19: comparator enable off by default; mode bit picks comparator or amp
// R20: analog pin count code n makes port 6 pins 0..n analog
// R21: converter clock code divides by 4, 16, 64 or uses ring oscillator
// R22: pull-down control low enables pull-down per port 6 pin
// R23: open-drain control low enables open drain per pin
`timescale 1ns/1ps
module mcsr_bank (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [7:0]  port5_pin,
   input  wire logic [7:0]  port6_pin,
   input  wire logic        ext_irq_pin,
   input  wire logic        timer_pin,
   input  wire logic        comparator_out,
   input  wire logic        conversion_complete,
   input  wire logic [7:0]  conversion_value,
   input  wire logic        pulse1_period,
   input  wire logic        pulse2_period,
   input  wire logic        watchdog_osc_tick,
   input  wire logic        enable_irq_instruction,
   input  wire logic        return_irq_instruction,
   input  wire logic        disable_irq_instruction,
   input  wire logic        irq_taken,
   output logic [7:0]       port5_out,
   output logic [7:0]       port5_oe,
   output logic [7:0]       port6_out,
   output logic [7:0]       port6_oe,
   output logic             bank_select,
   output logic [5:0]       indirect_index,
   output logic             segment_select,
   output logic             conversion_run,
   output logic             converter_power,
   output logic [2:0]       input_channel_select,
   output logic [7:0]       analog_pin_mask,
   output logic [1:0]       converter_clock_divide,
   output logic             vref_external,
   output logic             amp1_enable,
   output logic             amp2_enable,
   output logic [2:0]       amp1_gain,
   output logic [2:0]       amp2_gain,
   output logic             comparator_enable,
   output logic             comparator_output_mode,
   output logic [7:0]       pull_down_disable_n,
   output logic [7:0]       open_drain_disable_n,
   output logic             global_irq_enable,
   output logic             interrupt_pending,
   output logic             watchdog_tick
);

   typedef struct packed {
      logic [7:0]                  ram_sel;
      logic [7:0]                  p5_out;
      logic [7:0]                  p6_out;
      logic [5:0]                  conv_ctrl;
      logic [7:0]                  result;
      logic [6:0]                  flags;
      logic [6:0]                  mask;
      logic [7:0]                  tctl;
      logic [7:0]                  tcnt;
      logic [7:0]                  presc;
      logic [7:0]                  p5_dir;
      logic [7:0]                  p6_dir;
      logic [7:0]                  p5_oe;
      logic [7:0]                  p6_oe;
      logic [7:0]                  gain;
      logic [7:0]                  cmpcon;
      logic [7:0]                  analog;
      logic [7:0]                  pd;
      logic [7:0]                  od;
      logic [mcsr_pkg::SYNC_W-1:0] s1;
      logic [mcsr_pkg::SYNC_W-1:0] s2;
      logic [mcsr_pkg::SYNC_W-1:0] s3;
      logic [mcsr_pkg::SYNC_W-1:0] filt;
      logic                        aw_ok;
      logic [5:0]                  aw_idx;
      logic                        w_ok;
      logic [7:0]                  w_dat;
      logic                        w_lane0;
      logic                        bvalid;
      logic [1:0]                  bresp;
      logic                        rvalid;
      logic [7:0]                  rdata;
      logic [1:0]                  rresp;
      logic                        wdt_tick;
      logic                        pending;
   } mcsr_state_t;

   mcsr_state_t st_q;
   mcsr_state_t st_d;

   // segment one registers lie outside this bank, so they decode as unmapped
   function automatic logic mcsr_mapped(input logic [5:0] idx, input logic seg);
      logic [3:0] off;
      off = idx[3:0];
      if (idx == mcsr_pkg::IDX_TIMER_CNT || idx == mcsr_pkg::IDX_RAM_SEL ||
          idx == mcsr_pkg::IDX_PORT5 || idx == mcsr_pkg::IDX_PORT6 ||
          idx == mcsr_pkg::IDX_CONV_CTRL || idx == mcsr_pkg::IDX_CONV_RES ||
          idx == mcsr_pkg::IDX_FLAGS || idx == mcsr_pkg::IDX_TIMER_CTRL) begin
         return 1'b1;
      end else if (idx[5:4] == mcsr_pkg::IDX_SEG_BASE[5:4] && !seg) begin // R2
         return off == mcsr_pkg::SEG_P5_DIR || off == mcsr_pkg::SEG_P6_DIR ||
                off == mcsr_pkg::SEG_GAIN || off == mcsr_pkg::SEG_CMPCON ||
                off == mcsr_pkg::SEG_PULL_DOWN || off == mcsr_pkg::SEG_OPEN_DRAIN ||
                off == mcsr_pkg::SEG_IRQ_MASK;
      end else begin
         return 1'b0;
      end
   endfunction

   function automatic logic [7:0] mcsr_read(input mcsr_state_t s, input logic [5:0] idx);
      logic [3:0] off;
      off = idx[3:0];
      if (idx == mcsr_pkg::IDX_TIMER_CNT) begin
         return s.tcnt;
      end else if (idx == mcsr_pkg::IDX_RAM_SEL) begin
         return s.ram_sel;
      end else if (idx == mcsr_pkg::IDX_PORT5) begin
         return s.filt[7:0];
      end else if (idx == mcsr_pkg::IDX_PORT6) begin
         return s.filt[15:8];
      end else if (idx == mcsr_pkg::IDX_CONV_CTRL) begin
         return {2'h0, s.conv_ctrl};
      end else if (idx == mcsr_pkg::IDX_CONV_RES) begin
         return s.result;
      end else if (idx == mcsr_pkg::IDX_FLAGS) begin
         return {1'b0, s.flags & s.mask}; // R8 R9
      end else if (idx == mcsr_pkg::IDX_TIMER_CTRL) begin
         return s.tctl;
      end else if (off == mcsr_pkg::SEG_P5_DIR) begin
         return s.p5_dir;
      end else if (off == mcsr_pkg::SEG_P6_DIR) begin
         return s.p6_dir;
      end else if (off == mcsr_pkg::SEG_GAIN) begin
         return s.gain;
      end else if (off == mcsr_pkg::SEG_CMPCON) begin
         return s.cmpcon;
      end else if (off == mcsr_pkg::SEG_PULL_DOWN) begin
         return s.pd;
      end else if (off == mcsr_pkg::SEG_OPEN_DRAIN) begin
         return s.od;
      end else begin
         return {1'b0, s.mask};
      end
   endfunction

   // prescaler hit: all bits under the ratio mask set; timer ratio is one step coarser
   function automatic logic mcsr_ratio_hit(input logic [7:0] cnt, input logic [2:0] code,
                                           input logic timer);
      logic [7:0] m;
      m = timer ? 8'((9'h002 << code) - 9'h001) : 8'((9'h001 << code) - 9'h001);
      return (cnt & m) == m;
   endfunction

   logic       wr_fire;
   logic       rd_take;
   logic       wr_hit;
   logic [7:0] wv;
   logic [6:0] ev;
   logic       tick_src;
   logic       tmr_tick;
   logic       p6_change;
   logic       ext_edge;
   logic       tpin_edge;

   always_comb begin
      st_d      = st_q;
      // pins: port5, port6, ext irq, timer pin, comparator
      st_d.s1   = {comparator_out, timer_pin, ext_irq_pin, port6_pin, port5_pin};
      st_d.s2   = st_q.s1;
      st_d.s3   = st_q.s2;
      for (int i = 0; i < mcsr_pkg::SYNC_W; i++) begin
         if (st_q.s2[i] == st_q.s3[i]) begin
            st_d.filt[i] = st_q.s3[i];
         end
      end
      // analog pins are excluded from change detection
      p6_change = |((st_d.filt[15:8] ^ st_q.filt[15:8]) & ~st_q.analog); // R7
      ext_edge  = st_q.tctl[mcsr_pkg::TC_EDGE_SEL] ? (st_q.filt[16] && !st_d.filt[16])
                                                   : (!st_q.filt[16] && st_d.filt[16]); // R11
      tpin_edge = st_q.tctl[mcsr_pkg::TC_TIMER_EDGE] ? (st_q.filt[17] && !st_d.filt[17])
                                                     : (!st_q.filt[17] && st_d.filt[17]); // R14
      // AXI write: address and data taken in either order
      if (s_axi_awvalid && !st_q.aw_ok) begin
         st_d.aw_ok  = 1'b1;
         st_d.aw_idx = s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && !st_q.w_ok) begin
         st_d.w_ok    = 1'b1;
         st_d.w_dat   = s_axi_wdata[7:0];
         st_d.w_lane0 = s_axi_wstrb[0];
      end
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end
      wr_fire = st_q.aw_ok && st_q.w_ok && !st_q.bvalid;
      wr_hit  = wr_fire && st_q.w_lane0 && mcsr_mapped(st_q.aw_idx, st_q.conv_ctrl[mcsr_pkg::CC_SEGMENT]);
      wv      = st_q.w_dat;
      if (wr_fire) begin
         st_d.aw_ok  = 1'b0;
         st_d.w_ok   = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp  = mcsr_mapped(st_q.aw_idx, st_q.conv_ctrl[mcsr_pkg::CC_SEGMENT]) ?
                       mcsr_pkg::RESP_OKAY : mcsr_pkg::RESP_DECERR;
      end
      // timer and shared prescaler
      tick_src = st_q.tctl[mcsr_pkg::TC_SOURCE] ? tpin_edge : 1'b1; // R13
      tmr_tick = 1'b0;
      st_d.wdt_tick = 1'b0;
      if (!st_q.tctl[mcsr_pkg::TC_ASSIGN]) begin // R15
         if (tick_src) begin
            st_d.presc = st_q.presc + 8'h01;
            tmr_tick   = mcsr_ratio_hit(st_q.presc, st_q.tctl[2:0], 1'b1); // R16
         end
      end else begin
         tmr_tick = tick_src;
         if (watchdog_osc_tick) begin
            st_d.presc    = st_q.presc + 8'h01;
            st_d.wdt_tick = mcsr_ratio_hit(st_q.presc, st_q.tctl[2:0], 1'b0); // R16
         end
      end
      if (tmr_tick) begin
         st_d.tcnt = st_q.tcnt + 8'h01;
      end
      // register writes
      if (wr_hit) begin
         if (st_q.aw_idx == mcsr_pkg::IDX_TIMER_CNT) begin
            st_d.tcnt = wv;
            if (!st_q.tctl[mcsr_pkg::TC_ASSIGN]) begin
               st_d.presc = mcsr_pkg::RST_ZERO;
            end
         end else if (st_q.aw_idx == mcsr_pkg::IDX_RAM_SEL) begin
            st_d.ram_sel = wv; // R1
         end else if (st_q.aw_idx == mcsr_pkg::IDX_PORT5) begin
            st_d.p5_out = wv;
         end else if (st_q.aw_idx == mcsr_pkg::IDX_PORT6) begin
            st_d.p6_out = wv;
         end else if (st_q.aw_idx == mcsr_pkg::IDX_CONV_CTRL) begin
            st_d.conv_ctrl[mcsr_pkg::CC_SEGMENT] = wv[mcsr_pkg::CC_SEGMENT]; // R2
            st_d.conv_ctrl[mcsr_pkg::CC_POWER]   = wv[mcsr_pkg::CC_POWER];
            if (wv[mcsr_pkg::CC_RUN]) begin
               st_d.conv_ctrl[mcsr_pkg::CC_RUN] = 1'b1; // R3
            end
            if (!st_q.flags[mcsr_pkg::FL_CONV] && !st_q.conv_ctrl[mcsr_pkg::CC_RUN]) begin
               st_d.conv_ctrl[2:0] = wv[2:0]; // R4
            end
         end else if (st_q.aw_idx == mcsr_pkg::IDX_FLAGS) begin
            st_d.flags = st_q.flags & wv[6:0]; // R8
         end else if (st_q.aw_idx == mcsr_pkg::IDX_TIMER_CTRL) begin
            st_d.tctl = wv;
         end else if (st_q.aw_idx[3:0] == mcsr_pkg::SEG_P5_DIR) begin
            st_d.p5_dir = wv; // R17
         end else if (st_q.aw_idx[3:0] == mcsr_pkg::SEG_P6_DIR) begin
            st_d.p6_dir = wv; // R17
         end else if (st_q.aw_idx[3:0] == mcsr_pkg::SEG_GAIN) begin
            st_d.gain = wv; // R18
         end else if (st_q.aw_idx[3:0] == mcsr_pkg::SEG_CMPCON) begin
            st_d.cmpcon = wv; // R19 R21
         end else if (st_q.aw_idx[3:0] == mcsr_pkg::SEG_PULL_DOWN) begin
            st_d.pd = wv; // R22
         end else if (st_q.aw_idx[3:0] == mcsr_pkg::SEG_OPEN_DRAIN) begin
            st_d.od = wv; // R23
         end else begin
            st_d.mask = wv[6:0]; // R10
         end
      end
      // pins 0..n analog for code n
      st_d.analog = 8'((9'h002 << st_d.cmpcon[4:2]) - 9'h001); // R20
      st_d.p5_oe  = ~st_d.p5_dir; // R17
      st_d.p6_oe  = ~st_d.p6_dir; // R17
      // global enable: clearing events win over setting ones
      if (enable_irq_instruction || return_irq_instruction) begin
         st_d.tctl[mcsr_pkg::TC_GLOBAL_EN] = 1'b1; // R12
      end
      if (disable_irq_instruction || irq_taken) begin
         st_d.tctl[mcsr_pkg::TC_GLOBAL_EN] = 1'b0; // R12
      end
      // conversion end
      if (conversion_complete && st_q.conv_ctrl[mcsr_pkg::CC_RUN]) begin
         st_d.result = conversion_value; // R5
         st_d.conv_ctrl[mcsr_pkg::CC_RUN] = 1'b0; // R3 R5
      end
      // flag events applied after the software clear, so a set is never lost
      ev = '0;
      ev[mcsr_pkg::FL_CMP]    = st_q.filt[18] != st_d.filt[18]; // R6
      ev[mcsr_pkg::FL_PULSE2] = pulse2_period; // R6
      ev[mcsr_pkg::FL_PULSE1] = pulse1_period; // R6
      ev[mcsr_pkg::FL_CONV]   = conversion_complete && st_q.conv_ctrl[mcsr_pkg::CC_RUN]; // R5 R7
      ev[mcsr_pkg::FL_EXT]    = ext_edge; // R7
      ev[mcsr_pkg::FL_PORT]   = p6_change; // R7
      ev[mcsr_pkg::FL_TIMER]  = tmr_tick && st_q.tcnt == mcsr_pkg::RST_ONES; // R7
      st_d.flags   = st_d.flags | ev;
      st_d.pending = |(st_q.flags & st_q.mask) && st_q.tctl[mcsr_pkg::TC_GLOBAL_EN]; // R10
      // AXI read: one-cycle answer from the state at acceptance
      rd_take = s_axi_arvalid && !st_q.rvalid;
      if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
      end
      if (rd_take) begin
         st_d.rvalid = 1'b1;
         if (mcsr_mapped(s_axi_araddr[7:2], st_q.conv_ctrl[mcsr_pkg::CC_SEGMENT])) begin
            st_d.rdata = mcsr_read(st_q, s_axi_araddr[7:2]);
            st_d.rresp = mcsr_pkg::RESP_OKAY;
         end else begin
            st_d.rdata = mcsr_pkg::RST_ZERO;
            st_d.rresp = mcsr_pkg::RESP_DECERR;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q           <= '0;
         st_q.tctl      <= mcsr_pkg::RST_TIMER_CTRL;
         st_q.p5_dir    <= mcsr_pkg::RST_ONES;
         st_q.p6_dir    <= mcsr_pkg::RST_ONES;
         st_q.pd        <= mcsr_pkg::RST_ONES;
         st_q.od        <= mcsr_pkg::RST_ONES;
         st_q.analog    <= mcsr_pkg::RST_ANALOG;
      end else begin
         st_q <= st_d;
      end
   end

   assign s_axi_awready          = !st_q.aw_ok;
   assign s_axi_wready           = !st_q.w_ok;
   assign s_axi_bvalid           = st_q.bvalid;
   assign s_axi_bresp            = st_q.bresp;
   assign s_axi_arready          = !st_q.rvalid;
   assign s_axi_rvalid           = st_q.rvalid;
   assign s_axi_rdata            = {24'h000000, st_q.rdata};
   assign s_axi_rresp            = st_q.rresp;
   assign port5_out              = st_q.p5_out;
   assign port5_oe               = st_q.p5_oe;
   assign port6_out              = st_q.p6_out;
   assign port6_oe               = st_q.p6_oe;
   assign bank_select            = st_q.ram_sel[6];
   assign indirect_index         = st_q.ram_sel[5:0];
   assign segment_select         = st_q.conv_ctrl[mcsr_pkg::CC_SEGMENT];
   assign conversion_run         = st_q.conv_ctrl[mcsr_pkg::CC_RUN];
   assign converter_power        = st_q.conv_ctrl[mcsr_pkg::CC_POWER];
   assign input_channel_select   = st_q.conv_ctrl[2:0];
   assign analog_pin_mask        = st_q.analog;
   assign converter_clock_divide = st_q.cmpcon[1:0];
   assign vref_external          = st_q.cmpcon[7];
   assign comparator_enable      = st_q.cmpcon[6];
   assign comparator_output_mode = st_q.cmpcon[5];
   assign amp2_enable            = st_q.gain[7];
   assign amp1_enable            = st_q.gain[6];
   assign amp2_gain              = st_q.gain[5:3];
   assign amp1_gain              = st_q.gain[2:0];
   assign pull_down_disable_n    = st_q.pd;
   assign open_drain_disable_n   = st_q.od;
   assign global_irq_enable      = st_q.tctl[mcsr_pkg::TC_GLOBAL_EN];
   assign interrupt_pending      = st_q.pending;
   assign watchdog_tick          = st_q.wdt_tick;

   bank_bits_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
      bank_select == st_q.ram_sel[6] && indirect_index == st_q.ram_sel[5:0])
      else $error("bank select out of step");
   run_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // R3
      $fell(conversion_run) |-> $past(conversion_complete))
      else $error("run bit cleared without conversion end");
   chan_lock_a: assert property (@(posedge aclk) disable iff (!aresetn) // R4
      $changed(input_channel_select) |-> $past(!st_q.flags[3] && !conversion_run))
      else $error("channel changed while busy or done");
   conv_end_a: assert property (@(posedge aclk) disable iff (!aresetn) // R5
      conversion_complete && conversion_run |=> st_q.result == $past(conversion_value)
      && st_q.flags[3] && !conversion_run)
      else $error("conversion end not recorded");
   port_flag_a: assert property (@(posedge aclk) disable iff (!aresetn) // R7
      $rose(st_q.flags[1]) |-> $past(p6_change))
      else $error("port change flag set without cause");
   flag_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // R9
      rd_take && s_axi_araddr[7:2] == mcsr_pkg::IDX_FLAGS
      |=> s_axi_rdata[7:0] == {1'b0, $past(st_q.flags) & $past(st_q.mask)})
      else $error("status read not masked");
   global_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // R12
      disable_irq_instruction || irq_taken |=> !global_irq_enable)
      else $error("global enable not cleared");
   dir_drive_a: assert property (@(posedge aclk) disable iff (!aresetn) // R17
      port5_oe == ~st_q.p5_dir && port6_oe == ~st_q.p6_dir)
      else $error("output enable disagrees with direction");

endmodule // mcsr_bank

// ===== logic/mcsr_pkg.sv
/*
 * mcsr_pkg: register indices, field positions, reset values and codes for the
 * control/status register bank of the small 8-bit controller.
 * Assumes AXI4-Lite byte addresses equal four times the register index.
 */
package mcsr_pkg;
   localparam int          ADDR_W         = 8;
   localparam int          SYNC_W         = 19;
   // register indices, byte address is index * 4
   localparam logic [5:0]  IDX_TIMER_CNT  = 6'h01;
   localparam logic [5:0]  IDX_RAM_SEL    = 6'h04;
   localparam logic [5:0]  IDX_PORT5      = 6'h05;
   localparam logic [5:0]  IDX_PORT6      = 6'h06;
   localparam logic [5:0]  IDX_CONV_CTRL  = 6'h09;
   localparam logic [5:0]  IDX_CONV_RES   = 6'h0A;
   localparam logic [5:0]  IDX_FLAGS      = 6'h0F;
   localparam logic [5:0]  IDX_TIMER_CTRL = 6'h11;
   // control segment window: index = IDX_SEG_BASE + control offset
   localparam logic [5:0]  IDX_SEG_BASE   = 6'h20;
   localparam logic [3:0]  SEG_P5_DIR     = 4'h5;
   localparam logic [3:0]  SEG_P6_DIR     = 4'h6;
   localparam logic [3:0]  SEG_GAIN       = 4'h9;
   localparam logic [3:0]  SEG_CMPCON     = 4'hA;
   localparam logic [3:0]  SEG_PULL_DOWN  = 4'hB;
   localparam logic [3:0]  SEG_OPEN_DRAIN = 4'hC;
   localparam logic [3:0]  SEG_IRQ_MASK   = 4'hF;
   // converter control fields
   localparam int          CC_SEGMENT     = 5;
   localparam int          CC_RUN         = 4;
   localparam int          CC_POWER       = 3;
   // interrupt flag positions
   localparam int          FL_CMP         = 6;
   localparam int          FL_PULSE2      = 5;
   localparam int          FL_PULSE1      = 4;
   localparam int          FL_CONV        = 3;
   localparam int          FL_EXT         = 2;
   localparam int          FL_PORT        = 1;
   localparam int          FL_TIMER       = 0;
   // timer control fields
   localparam int          TC_EDGE_SEL    = 7;
   localparam int          TC_GLOBAL_EN   = 6;
   localparam int          TC_SOURCE      = 5;
   localparam int          TC_TIMER_EDGE  = 4;
   localparam int          TC_ASSIGN      = 3;
   // reset values
   localparam logic [7:0]  RST_ZERO       = 8'h00;
   localparam logic [7:0]  RST_ONES       = 8'hFF;
   localparam logic [7:0]  RST_TIMER_CTRL = 8'h3F;
   localparam logic [7:0]  RST_ANALOG     = 8'h01;
   // AXI responses
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_DECERR    = 2'h3;
endpackage
